// *** src/config_fuse_decode.sv ***
`timescale 1ns/100ps
// Purpose: Configuration byte bank on Wishbone with field decode
// Assumes: Classic Wishbone, 32-bit data, byte in lane 0
// Notes:   Written bytes take effect only on an apply write; reset reloads the unprogrammed bank
//
// Contract
// [R1] Watchdog postscale ratio is one to two to the power code.
// [R2] Watchdog force bit runs it; otherwise software enable decides.
// [R3] Wait disable bit gives zero wait states, else separate field.
// [R4] Data width bit selects 16-bit or 8-bit external bus.
// [R5] Address width field selects 20, 16, 12 or 8 bits.
// [R6] Memory mode field selects one of four processor modes.
// [R7] Reset pin bit picks active-low master reset or plain input.
// [R8] Timer oscillator bit picks low-power or higher-power drive.
// [R9] Aux PWM outputs go to port E when set, port H otherwise.
// [R10] Compare2 to port C when set, else port B or E by mode.
// [R11] Debugger enabled when its bit is zero, pins then dedicated.
// [R12] Extension bit enables extended instructions and indexed addressing.
// [R13] Boot size field: 4K, 4K, 2K or 1K words.
// [R14] Single-supply bit enables low-voltage programming entry.
// [R15] Stack fault resets device only when enable bit set.
// [R16] Eight protect bits guard 16 Kbyte blocks; zero means protected.
// [R17] Block zero starts after boot block and ends at 3FFFh.
// [R18] Unimplemented bits read back as zero.
// [R19] Programmer keeps protect bits of absent blocks at one.
// [R20] Bytes apply at reset; decoded outputs stay stable afterwards. Code applies bytes on an apply write; reset reloads the unprogrammed bank.
module config_fuse_decode (
    // Clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       ce_i,
    // Wishbone slave
    input  wire logic                       cyc_i,
    input  wire logic                       stb_i,
    input  wire logic                       we_i,
    input  wire logic [25:0]                adr_i,
    input  wire logic [3:0]                 sel_i,
    input  wire logic [31:0]                dat_i,
    output logic      [31:0]                dat_o,
    output logic                            ack_o,
    // Device inputs
    input  wire logic                       wdog_soft_on_i,
    input  wire logic [1:0]                 wait_field_i,
    input  wire logic                       reset_pin_n_i,
    input  wire logic                       stack_fault_i,
    input  wire logic [20:0]                code_addr_i,
    // Decoded controls
    output logic      [15:0]                wdog_ratio_o,
    output logic                            wdog_run_o,
    output logic      [1:0]                 wait_states_o,
    output logic                            ext_data_16_o,
    output logic      [4:0]                 ext_addr_bits_o,
    output config_fuse_pkg::mem_mode_e      memory_mode_o,
    output logic                            master_reset_o,
    output logic                            port_pin_in_o,
    output logic                            port_pin_in_en_o,
    output logic                            lowpower_timer_osc_o,
    output logic                            pwm_aux_on_port_e_o,
    output config_fuse_pkg::cmp2_pin_e      compare2_pin_o,
    output logic                            debugger_en_o,
    output logic                            ext_instr_enable_o,
    output logic      [12:0]                boot_words_o,
    output logic      [20:0]                block0_start_o,
    output logic                            single_supply_prog_en_o,
    output logic                            stack_reset_o,
    output logic      [7:0]                 block_protected_o,
    output logic                            code_protected_o
);

    typedef struct packed {
        config_fuse_pkg::cfg_bank_t cells;
        config_fuse_pkg::cfg_bank_t applied;
        logic                       ack;
        logic [7:0]                 rdata;
    } state_s;

    state_s                     st;
    state_s                     next_st;
    config_fuse_pkg::cfg_bank_t rst_bank;
    config_fuse_pkg::cfg_bank_t mask_bank;
    logic [23:0]                idx;
    logic                       hit;
    logic                       hit_apply;
    logic [2:0]                 slot;
    logic                       pending;

    config_decode_if dec ();

    assign rst_bank = {config_fuse_pkg::RST_BLOCK_PROT,
                       config_fuse_pkg::RST_CORE_OPT,
                       config_fuse_pkg::RST_PIN_SELECT,
                       config_fuse_pkg::RST_EXT_BUS,
                       config_fuse_pkg::RST_WATCHDOG};
    assign mask_bank = {config_fuse_pkg::MASK_BLOCK_PROT,
                        config_fuse_pkg::MASK_CORE_OPT,
                        config_fuse_pkg::MASK_PIN_SELECT,
                        config_fuse_pkg::MASK_EXT_BUS,
                        config_fuse_pkg::MASK_WATCHDOG};
    assign idx = adr_i[25:2];
    assign pending = (st.cells != st.applied);

    // Address decode
    always_comb begin
        hit = 1'b1;
        hit_apply = 1'b0;
        slot = 3'h0;
        unique case (idx)
            config_fuse_pkg::IDX_WATCHDOG:   slot = 3'h0;
            config_fuse_pkg::IDX_EXT_BUS:    slot = 3'h1;
            config_fuse_pkg::IDX_PIN_SELECT: slot = 3'h2;
            config_fuse_pkg::IDX_CORE_OPT:   slot = 3'h3;
            config_fuse_pkg::IDX_BLOCK_PROT: slot = 3'h4;
            config_fuse_pkg::IDX_APPLY_CTRL: begin
                hit = 1'b0;
                hit_apply = 1'b1;
            end
            default: hit = 1'b0;
        endcase
    end

    always_comb begin
        next_st = st;
        // Ack drops the cycle after it is given
        next_st.ack = cyc_i && stb_i && !st.ack;
        if (cyc_i && stb_i && !st.ack) begin
            next_st.rdata = 8'h00;
            if (hit) begin
                // Unimplemented positions never store or read a one
                next_st.rdata = st.cells[slot] & mask_bank[slot]; // see [R18]
                if (we_i && sel_i[0]) begin
                    next_st.cells[slot] = dat_i[7:0] & mask_bank[slot]; // see [R18]
                end
            end else if (hit_apply) begin
                next_st.rdata = {7'h00, pending};
                if (we_i && sel_i[0] && dat_i[config_fuse_pkg::POS_APPLY]) begin
                    // Applied bytes change only here or at reset, never mid-write
                    next_st.applied = st.cells; // see [R20]
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // Reset reloads the unprogrammed bank into both copies
            st.cells <= rst_bank; // see [R20]
            st.applied <= rst_bank; // see [R20]
            st.ack <= 1'b0;
            st.rdata <= 8'h00;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    assign dat_o = {24'h000000, st.rdata};
    assign ack_o = st.ack;

    // Decoder sees only the applied copy, so outputs decoded from the bytes alone hold steady
    assign dec.cfg = st.applied; // see [R20]
    assign dec.wdog_soft_on = wdog_soft_on_i;
    assign dec.wait_field = wait_field_i;
    assign dec.reset_pin_n = reset_pin_n_i;
    assign dec.stack_fault = stack_fault_i;
    assign dec.code_addr = code_addr_i;

    config_field_decode u_decode (
        .dec (dec.decode)
    );

    assign wdog_ratio_o = dec.wdog_ratio;
    assign wdog_run_o = dec.wdog_run;
    assign wait_states_o = dec.wait_states;
    assign ext_data_16_o = dec.ext_data_16;
    assign ext_addr_bits_o = dec.ext_addr_bits;
    assign memory_mode_o = dec.memory_mode;
    assign master_reset_o = dec.master_reset;
    assign port_pin_in_o = dec.port_pin_in;
    assign port_pin_in_en_o = dec.port_pin_in_en;
    assign lowpower_timer_osc_o = dec.lowpower_timer_osc;
    assign pwm_aux_on_port_e_o = dec.pwm_aux_on_port_e;
    assign compare2_pin_o = dec.compare2_pin;
    assign debugger_en_o = dec.debugger_en;
    assign ext_instr_enable_o = dec.ext_instr_enable;
    assign boot_words_o = dec.boot_words;
    assign block0_start_o = dec.block0_start;
    assign single_supply_prog_en_o = dec.single_supply_prog_en;
    assign stack_reset_o = dec.stack_reset;
    assign block_protected_o = dec.block_protected;
    assign code_protected_o = dec.code_protected;

endmodule // config_fuse_decode

// *** src/config_fuse_pkg.sv ***
// Purpose: Constants for the configuration byte bank and its decode
// Assumes: Byte registers sit in the low lane of a 32-bit Wishbone word
// Notes:   Register indices are word indices; byte address is index * 4
package config_fuse_pkg;

    // Register indices (word address = index)
    localparam logic [23:0] IDX_WATCHDOG   = 24'h300003;
    localparam logic [23:0] IDX_EXT_BUS    = 24'h300004;
    localparam logic [23:0] IDX_PIN_SELECT = 24'h300005;
    localparam logic [23:0] IDX_CORE_OPT   = 24'h300006;
    localparam logic [23:0] IDX_BLOCK_PROT = 24'h300008;
    localparam logic [23:0] IDX_APPLY_CTRL = 24'h300010;

    // Slot numbers inside the byte bank
    localparam int SLOT_WATCHDOG   = 0;
    localparam int SLOT_EXT_BUS    = 1;
    localparam int SLOT_PIN_SELECT = 2;
    localparam int SLOT_CORE_OPT   = 3;
    localparam int SLOT_BLOCK_PROT = 4;
    localparam int NUM_SLOTS       = 5;

    // Implemented-bit masks
    localparam logic [7:0] MASK_WATCHDOG   = 8'h1F;
    localparam logic [7:0] MASK_EXT_BUS    = 8'hF3;
    localparam logic [7:0] MASK_PIN_SELECT = 8'h87;
    localparam logic [7:0] MASK_CORE_OPT   = 8'hF5;
    localparam logic [7:0] MASK_BLOCK_PROT = 8'hFF;

    // Unprogrammed values
    localparam logic [7:0] RST_WATCHDOG   = 8'h1F;
    localparam logic [7:0] RST_EXT_BUS    = 8'hF3;
    localparam logic [7:0] RST_PIN_SELECT = 8'h83;
    localparam logic [7:0] RST_CORE_OPT   = 8'h85;
    localparam logic [7:0] RST_BLOCK_PROT = 8'hFF;

    // Field positions
    localparam int POS_WDOG_FORCE  = 0;
    localparam int POS_WDOG_PS     = 1;
    localparam int POS_MEM_MODE    = 0;
    localparam int POS_ADDR_WIDTH  = 4;
    localparam int POS_DATA_WIDTH  = 6;
    localparam int POS_WAIT_OFF    = 7;
    localparam int POS_COMPARE2    = 0;
    localparam int POS_PWM_AUX     = 1;
    localparam int POS_LP_TIMER    = 2;
    localparam int POS_RESET_PIN   = 7;
    localparam int POS_STACK_RST   = 0;
    localparam int POS_SINGLE_PROG = 2;
    localparam int POS_BOOT_SIZE   = 4;
    localparam int POS_EXT_INSTR   = 6;
    localparam int POS_DEBUG_OFF   = 7;
    localparam int POS_APPLY       = 0;

    // Address bus widths in bits
    localparam logic [4:0] ADDR_BITS_8  = 5'h08;
    localparam logic [4:0] ADDR_BITS_12 = 5'h0C;
    localparam logic [4:0] ADDR_BITS_16 = 5'h10;
    localparam logic [4:0] ADDR_BITS_20 = 5'h14;

    // Boot block end (first word after), program byte addresses
    localparam logic [20:0] BOOT_END_1K  = 21'h000800;
    localparam logic [20:0] BOOT_END_2K  = 21'h001000;
    localparam logic [20:0] BOOT_END_4K  = 21'h002000;
    localparam logic [20:0] PROG_TOP     = 21'h020000;
    localparam int          BLOCK_SHIFT  = 14;

    typedef enum logic [1:0] {
        MODE_EXT_MCU,
        MODE_MPU_BOOT,
        MODE_MPU,
        MODE_MCU
    } mem_mode_e;

    typedef enum logic [1:0] {
        CMP2_PORT_C,
        CMP2_PORT_B,
        CMP2_PORT_E
    } cmp2_pin_e;

    typedef logic [NUM_SLOTS-1:0][7:0] cfg_bank_t;

endpackage

// *** src/config_decode_if.sv ***
`timescale 1ns/100ps
// Purpose: Carries the applied byte bank to the decoder and results back
// Assumes: Single clock domain, purely combinational decode
// Notes:   None
interface config_decode_if;
    config_fuse_pkg::cfg_bank_t  cfg;
    logic                        wdog_soft_on;
    logic [1:0]                  wait_field;
    logic                        reset_pin_n;
    logic                        stack_fault;
    logic [20:0]                 code_addr;

    logic [15:0]                 wdog_ratio;
    logic                        wdog_run;
    logic [1:0]                  wait_states;
    logic                        ext_data_16;
    logic [4:0]                  ext_addr_bits;
    config_fuse_pkg::mem_mode_e  memory_mode;
    logic                        master_reset;
    logic                        port_pin_in;
    logic                        port_pin_in_en;
    logic                        lowpower_timer_osc;
    logic                        pwm_aux_on_port_e;
    config_fuse_pkg::cmp2_pin_e  compare2_pin;
    logic                        debugger_en;
    logic                        ext_instr_enable;
    logic [12:0]                 boot_words;
    logic [20:0]                 block0_start;
    logic                        single_supply_prog_en;
    logic                        stack_reset;
    logic [7:0]                  block_protected;
    logic                        code_protected;

    modport bank (
        output cfg, wdog_soft_on, wait_field, reset_pin_n, stack_fault,
               code_addr,
        input  wdog_ratio, wdog_run, wait_states, ext_data_16,
               ext_addr_bits, memory_mode, master_reset, port_pin_in,
               port_pin_in_en, lowpower_timer_osc, pwm_aux_on_port_e,
               compare2_pin, debugger_en, ext_instr_enable, boot_words,
               block0_start, single_supply_prog_en, stack_reset,
               block_protected, code_protected
    );
    modport decode (
        input  cfg, wdog_soft_on, wait_field, reset_pin_n, stack_fault,
               code_addr,
        output wdog_ratio, wdog_run, wait_states, ext_data_16,
               ext_addr_bits, memory_mode, master_reset, port_pin_in,
               port_pin_in_en, lowpower_timer_osc, pwm_aux_on_port_e,
               compare2_pin, debugger_en, ext_instr_enable, boot_words,
               block0_start, single_supply_prog_en, stack_reset,
               block_protected, code_protected
    );
endinterface

// *** src/config_field_decode.sv ***
`timescale 1ns/100ps
// Purpose: Turns the applied configuration bytes into device controls
// Assumes: Bank is held stable by the owner between applies
// Notes:   Combinational only
module config_field_decode (
    config_decode_if.decode dec
);
    logic [7:0]  wd;
    logic [7:0]  eb;
    logic [7:0]  ps;
    logic [7:0]  co;
    logic [1:0]  boot_sel;
    logic [2:0]  blk_idx;

    assign wd = dec.cfg[config_fuse_pkg::SLOT_WATCHDOG];
    assign eb = dec.cfg[config_fuse_pkg::SLOT_EXT_BUS];
    assign ps = dec.cfg[config_fuse_pkg::SLOT_PIN_SELECT];
    assign co = dec.cfg[config_fuse_pkg::SLOT_CORE_OPT];
    assign boot_sel = co[config_fuse_pkg::POS_BOOT_SIZE +: 2];
    assign blk_idx = dec.code_addr[config_fuse_pkg::BLOCK_SHIFT +: 3];

    always_comb begin
        // Ratio 1:2^code
        dec.wdog_ratio = 16'h0001 << wd[config_fuse_pkg::POS_WDOG_PS +: 4]; // see [R1]
        dec.wdog_run = wd[config_fuse_pkg::POS_WDOG_FORCE]
                       | dec.wdog_soft_on; // see [R2]
        dec.wait_states = eb[config_fuse_pkg::POS_WAIT_OFF]
                          ? 2'h0 : dec.wait_field; // see [R3]
        dec.ext_data_16 = eb[config_fuse_pkg::POS_DATA_WIDTH]; // see [R4]
        unique case (eb[config_fuse_pkg::POS_ADDR_WIDTH +: 2]) // see [R5]
            2'h3: dec.ext_addr_bits = config_fuse_pkg::ADDR_BITS_20;
            2'h2: dec.ext_addr_bits = config_fuse_pkg::ADDR_BITS_16;
            2'h1: dec.ext_addr_bits = config_fuse_pkg::ADDR_BITS_12;
            2'h0: dec.ext_addr_bits = config_fuse_pkg::ADDR_BITS_8;
        endcase
        dec.memory_mode = config_fuse_pkg::mem_mode_e'(
            eb[config_fuse_pkg::POS_MEM_MODE +: 2]); // see [R6]
        // Pin is active low reset or plain input, never both
        dec.port_pin_in_en = !ps[config_fuse_pkg::POS_RESET_PIN]; // see [R7]
        dec.master_reset = ps[config_fuse_pkg::POS_RESET_PIN]
                           & !dec.reset_pin_n; // see [R7]
        dec.port_pin_in = dec.port_pin_in_en & dec.reset_pin_n; // see [R7]
        dec.lowpower_timer_osc = ps[config_fuse_pkg::POS_LP_TIMER]; // see [R8]
        dec.pwm_aux_on_port_e = ps[config_fuse_pkg::POS_PWM_AUX]; // see [R9]
        if (ps[config_fuse_pkg::POS_COMPARE2]) begin // see [R10]
            dec.compare2_pin = config_fuse_pkg::CMP2_PORT_C;
        end else if (dec.memory_mode == config_fuse_pkg::MODE_MCU) begin
            dec.compare2_pin = config_fuse_pkg::CMP2_PORT_E;
        end else begin
            dec.compare2_pin = config_fuse_pkg::CMP2_PORT_B;
        end
        dec.debugger_en = !co[config_fuse_pkg::POS_DEBUG_OFF]; // see [R11]
        dec.ext_instr_enable = co[config_fuse_pkg::POS_EXT_INSTR]; // see [R12]
        unique case (boot_sel) // see [R13] [R17]
            2'h3, 2'h2: begin
                dec.boot_words = 13'h1000;
                dec.block0_start = config_fuse_pkg::BOOT_END_4K;
            end
            2'h1: begin
                dec.boot_words = 13'h0800;
                dec.block0_start = config_fuse_pkg::BOOT_END_2K;
            end
            2'h0: begin
                dec.boot_words = 13'h0400;
                dec.block0_start = config_fuse_pkg::BOOT_END_1K;
            end
        endcase
        dec.single_supply_prog_en =
            co[config_fuse_pkg::POS_SINGLE_PROG]; // see [R14]
        dec.stack_reset = co[config_fuse_pkg::POS_STACK_RST]
                          & dec.stack_fault; // see [R15]
        // Zero bit means protected
        dec.block_protected =
            ~dec.cfg[config_fuse_pkg::SLOT_BLOCK_PROT]; // see [R16]
        // Boot block itself is guarded elsewhere, so not flagged here
        if (dec.code_addr >= config_fuse_pkg::PROG_TOP
            || dec.code_addr < dec.block0_start) begin // see [R17]
            dec.code_protected = 1'b0;
        end else begin
            dec.code_protected = dec.block_protected[blk_idx]; // see [R16]
        end
    end
endmodule // config_field_decode

// *** verification/config_fuse_decode_sva.sv ***
`timescale 1ns/100ps
// Purpose: Port-level checks for the configuration byte bank
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to the top module; sees its ports only
module config_fuse_decode_sva (
    // Bus
    input wire logic        clk_i, rst_i, ce_i, cyc_i, stb_i, we_i,
    input wire logic [25:0] adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i, dat_o,
    input wire logic        ack_o,
    // Device side
    input wire logic        wdog_soft_on_i, reset_pin_n_i, stack_fault_i,
    input wire logic [1:0]  wait_field_i, wait_states_o,
    input wire logic [20:0] code_addr_i, block0_start_o,
    input wire logic [15:0] wdog_ratio_o,
    input wire logic        wdog_run_o, ext_data_16_o, master_reset_o,
    input wire logic        port_pin_in_en_o, stack_reset_o,
    input wire logic        code_protected_o,
    input wire logic [4:0]  ext_addr_bits_o,
    input wire logic [12:0] boot_words_o,
    input wire logic [7:0]  block_protected_o,
    input config_fuse_pkg::mem_mode_e memory_mode_o,
    input config_fuse_pkg::cmp2_pin_e compare2_pin_o
);
    logic apply_hit;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    assign apply_hit = cyc_i && stb_i && ce_i && !ack_o && we_i && sel_i[0]
        && dat_i[0] && adr_i[25:2] == config_fuse_pkg::IDX_APPLY_CTRL;

    sequence req_taken;
        cyc_i && stb_i && ce_i && !ack_o;
    endsequence
    sequence apply_taken;
        req_taken ##0 apply_hit;
    endsequence

    chk_ack_next: assert property (req_taken |=> ack_o)
        else $error("no ack after request");
    chk_ack_single: assert property (ack_o && ce_i |=> !ack_o)
        else $error("ack longer than one cycle");
    chk_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    chk_upper_zero: assert property (dat_o[31:8] == 24'h000000)
        else $error("read data upper bits set");
    chk_ratio_onehot: assert property ($onehot(wdog_ratio_o))
        else $error("postscale ratio not a power of two");
    chk_wdog_soft: assert property (wdog_soft_on_i |-> wdog_run_o)
        else $error("watchdog off while enabled by software");
    chk_wait_zero: assert property (wait_states_o == 2'h0
        || wait_states_o == wait_field_i) else $error("bad wait count");
    chk_addr_width: assert property (ext_addr_bits_o inside
        {5'h08, 5'h0C, 5'h10, 5'h14}) else $error("bad address width");
    chk_reset_pin: assert property (master_reset_o |->
        !reset_pin_n_i && !port_pin_in_en_o) else $error("bad reset pin");
    chk_cmp2_mode: assert property (compare2_pin_o !=
        config_fuse_pkg::CMP2_PORT_C |-> (compare2_pin_o ==
        config_fuse_pkg::CMP2_PORT_E) == (memory_mode_o ==
        config_fuse_pkg::MODE_MCU)) else $error("compare pin vs mode");
    chk_stack_cause: assert property (stack_reset_o |-> stack_fault_i)
        else $error("stack reset without fault");
    chk_boot_start: assert property (block0_start_o ==
        {7'h00, boot_words_o, 1'b0}) else $error("block start vs boot size");
    chk_code_prot: assert property (code_protected_o |->
        block_protected_o[code_addr_i[16:14]] && code_addr_i >= block0_start_o)
        else $error("protection outside a protected block");
    chk_hold_stable: assert property (!$past(apply_hit) && !$past(rst_i)
        |-> $stable({ext_data_16_o, ext_addr_bits_o, memory_mode_o,
        boot_words_o, block_protected_o})) else $error("controls moved");
    chk_apply_ack: cover property (apply_taken ##1 ack_o);
endmodule // config_fuse_decode_sva

bind config_fuse_decode config_fuse_decode_sva u_sva (.*);

// *** verification/tb_config_fuse_decode.sv ***
`timescale 1ns/100ps
// Purpose: Self-checking bench for the configuration byte bank
// Assumes: Byte lane 0 of a classic Wishbone word
// Notes:   Rows cover every two-bit code; odd cases follow the loop
module tb_config_fuse_decode;
    logic        clk_i, rst_i, ce_i, cyc_i, stb_i, we_i;
    logic [25:0] adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i, dat_o;
    logic        ack_o, wdog_soft_on_i, reset_pin_n_i, stack_fault_i;
    logic [1:0]  wait_field_i, wait_states_o;
    logic [20:0] code_addr_i, block0_start_o;
    logic [15:0] wdog_ratio_o;
    logic        wdog_run_o, ext_data_16_o, master_reset_o, port_pin_in_o;
    logic        port_pin_in_en_o, lowpower_timer_osc_o, pwm_aux_on_port_e_o;
    logic        debugger_en_o, ext_instr_enable_o, single_supply_prog_en_o;
    logic        stack_reset_o, code_protected_o;
    logic [4:0]  ext_addr_bits_o;
    logic [12:0] boot_words_o;
    logic [7:0]  block_protected_o, q;
    config_fuse_pkg::mem_mode_e memory_mode_o;
    config_fuse_pkg::cmp2_pin_e compare2_pin_o;
    int          failures, n_checks;
    logic [4:0][7:0] cur;
    typedef struct packed { logic [4:0][7:0] b; logic [20:0] a; } row_s;
    row_s        rows [4] = '{ // Full part
        '{{8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 21'h000800},
        '{{8'hA5, 8'h5B, 8'h7A, 8'hDD, 8'hFF}, 21'h000FFE},
        '{{8'h5A, 8'hA6, 8'h85, 8'h22, 8'h0B}, 21'h01FFFF},
        '{{8'hFE, 8'hF3, 8'h04, 8'h33, 8'h1E}, 21'h020000}};
    logic [23:0] idx_tab [5] = '{24'h300003, 24'h300004, 24'h300005,
                                 24'h300006, 24'h300008};
    logic [7:0]  mask_tab [5] = '{8'h1F, 8'hF3, 8'h87, 8'hF5, 8'hFF};

    config_fuse_decode dut (.*);

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic tally_and_finish;
        if (failures == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // Holds the request until ack is seen high at a falling edge
    task automatic wb(input logic w, input logic [23:0] idx,
                      input logic [7:0] d, input logic [3:0] s);
        int n;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i} <= {2'b11, w};
        adr_i <= {idx, 2'b00};
        dat_i <= {24'h000000, d};
        sel_i <= s;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (ack_o !== 1'b1) begin
            failures++;
            $display("unexpected at %0t: no ack", $time);
            tally_and_finish;
        end
        @(posedge clk_i);
        q = dat_o[7:0];
        {cyc_i, stb_i} <= 2'b00;
    endtask

    task automatic read_all(input logic [4:0][7:0] e);
        for (int s = 0; s < 5; s++) begin
            wb(1'b0, idx_tab[s], 8'h00, 4'hF);
            chk(q, e[s] & mask_tab[s]);
        end
    endtask

    task automatic check_dec(input logic [4:0][7:0] b);
        logic [12:0] bw;
        logic [20:0] st;
        @(negedge clk_i);
        bw = b[3][5] ? 13'h1000 : (b[3][4] ? 13'h0800 : 13'h0400);
        st = {7'h00, bw, 1'b0};
        chk(wdog_ratio_o, 32'h1 << b[0][4:1]);
        chk(wdog_run_o, b[0][0] | wdog_soft_on_i);
        chk(wait_states_o, b[1][7] ? 2'h0 : wait_field_i);
        chk(ext_data_16_o, b[1][6]);
        chk(ext_addr_bits_o, {b[1][5:4], 2'h0} + 5'h08);
        chk(memory_mode_o, b[1][1:0]);
        chk({master_reset_o, port_pin_in_en_o, port_pin_in_o}, b[2][7] ?
            {!reset_pin_n_i, 2'b00} : {2'b01, reset_pin_n_i});
        chk(lowpower_timer_osc_o, b[2][2]);
        chk(pwm_aux_on_port_e_o, b[2][1]);
        chk(compare2_pin_o, b[2][0] ? 2'h0 :
            (b[1][1:0] == 2'h3 ? 2'h2 : 2'h1));
        chk(debugger_en_o, !b[3][7]);
        chk(ext_instr_enable_o, b[3][6]);
        chk(boot_words_o, bw);
        chk(block0_start_o, st);
        chk(single_supply_prog_en_o, b[3][2]);
        chk(stack_reset_o, b[3][0] & stack_fault_i);
        chk(block_protected_o, b[4] ^ 8'hFF);
        chk(code_protected_o, code_addr_i >= st && code_addr_i < 21'h020000
            && !b[4][code_addr_i[16:14]]);
    endtask

    initial begin
        {cyc_i, stb_i, we_i, rst_i, ce_i} = 5'b00011;
        {adr_i, sel_i, dat_i, wait_field_i} = '0;
        {wdog_soft_on_i, reset_pin_n_i, stack_fault_i} = 3'b010;
        code_addr_i = 21'h000800;
        failures = 0;
        n_checks = 0;
        cur = {8'hFF, 8'h85, 8'h83, 8'hF3, 8'h1F};
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        read_all(cur);
        check_dec(cur);
        foreach (rows[i]) begin
            @(posedge clk_i);
            {wdog_soft_on_i, reset_pin_n_i, stack_fault_i} <=
                {i[0], i[1], !i[0]};
            wait_field_i <= 2'(i + 1);
            code_addr_i <= rows[i].a;
            for (int s = 0; s < 5; s++) wb(1'b1, idx_tab[s], rows[i].b[s], 4'h1);
            read_all(rows[i].b);
            check_dec(cur);
            wb(1'b1, config_fuse_pkg::IDX_APPLY_CTRL, 8'h01, 4'h1);
            for (int s = 0; s < 5; s++) cur[s] = rows[i].b[s] & mask_tab[s];
            check_dec(cur);
        end
        // Every postscale code with the force bit clear
        for (int c = 0; c < 16; c++) begin
            cur[0] = 8'(c << 1);
            wb(1'b1, config_fuse_pkg::IDX_WATCHDOG, cur[0], 4'h1);
            wb(1'b1, config_fuse_pkg::IDX_APPLY_CTRL, 8'h01, 4'h1);
            check_dec(cur);
        end
        // Unmapped place, then a write with lane 0 disabled
        wb(1'b1, 24'h300007, 8'hFF, 4'hF);
        wb(1'b0, 24'h300007, 8'h00, 4'hF);
        chk(q, 8'h00);
        wb(1'b1, idx_tab[1], 8'h00, 4'hE);
        wb(1'b0, idx_tab[1], 8'h00, 4'hF);
        chk(q, cur[1]);
        @(posedge clk_i);
        ce_i <= 1'b0;
        fork
            wb(1'b0, idx_tab[0], 8'h00, 4'hF);
            begin
                repeat (3) @(negedge clk_i) chk(ack_o, 1'b0);
                @(posedge clk_i) ce_i <= 1'b1;
            end
        join
        chk(q, cur[0]);
        wb(1'b1, idx_tab[0], 8'h01, 4'h1);
        wb(1'b0, config_fuse_pkg::IDX_APPLY_CTRL, 8'h00, 4'hF);
        chk(q, 8'h01);
        check_dec(cur);
        // Reset in mid-run reloads the erased bytes
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        cur = {8'hFF, 8'h85, 8'h83, 8'hF3, 8'h1F};
        read_all(cur);
        check_dec(cur);
        wb(1'b0, config_fuse_pkg::IDX_APPLY_CTRL, 8'h00, 4'hF);
        chk(q, 8'h00);
        tally_and_finish;
    end
endmodule // tb_config_fuse_decode
